// ### hw/sec_pkg.sv
// Package of constants and types for the serial eeprom command core
package sec_pkg;
  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DEPTH = 512;
  localparam int PAGE_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_MAX = 9'h1ff;
  // Protected region starts per protect-select value
  localparam logic [ADDR_W-1:0] PROT_QUARTER = 9'h180;
  localparam logic [ADDR_W-1:0] PROT_HALF = 9'h100;
  localparam logic [ADDR_W-1:0] PROT_FULL = 9'h000;
  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_X_MASK = 8'hf7;
  localparam int OP_A8_BIT = 3;
  // ---------------------------------------------------------------
  // Status register layout
  // ---------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_PLO = 2;
  localparam int ST_PHI = 3;
  localparam logic [3:0] ST_ONES = 4'hf;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int WRITE_CYCLE_MS = 5;
  localparam int WRITE_CYCLES = WRITE_CYCLE_MS * 1000 * CLK_MHZ;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SEC_IDLE,
    SEC_OPC,
    SEC_ADDR,
    SEC_WDATA,
    SEC_SWDATA,
    SEC_RDOUT,
    SEC_SKIP
  } sec_state_t;
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
    logic hold_n;
  } sec_pins_t;
endpackage : sec_pkg

// ### hw/sec_core.sv
// Serial eeprom command, protection and array core
//
// How it works
// - Busy flag high through programming, read-only
// - Latch set and cleared by its commands
// - Status bits 7..4 ones, protect, latch, busy
// - Protect bits loaded only by status write
// - Status write alters only bits 2, 3
// - Protect codes guard none, quarter, half, all
// - Program only when latched and unguarded
// - Latch cleared at power-up
// - Latch set only on select rise
// - Write opcode, address, data; bit3 ninth
// - Programming starts on select rise
// - Busy ignores everything but status read
// - Page load wraps within sixteen bytes
// - Latch clears when programming ends
// - Low write guard blocks all writes
// - Guard fall aborts pending, not running
// - Read opcode, address, then data streams
// - Sequential read wraps, runs until deselect
// - Status read works any time
// - Hold floats output, ignores input
// - Decode six opcodes, ignore others
// - Sample rising clock, drive falling
// - Deselected output floats
`timescale 1ns/1ns
`default_nettype none
module sec_core #(
  parameter int WRITE_CYCLES = sec_pkg::WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire sec_pkg::sec_pins_t pins,
  output logic so_o,
  output logic so_oe_n,
  output logic busy
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  sec_pkg::sec_pins_t s1_r;
  sec_pkg::sec_pins_t s2_r;
  sec_pkg::sec_pins_t s3_r;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // Idle pin levels, so no false edge follows reset
      s1_r <= 5'h13;
      s2_r <= 5'h13;
      s3_r <= 5'h13;
    end
    else
    begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  wire logic sel = !s2_r.cs_n;
  wire logic cs_rise = s2_r.cs_n && !s3_r.cs_n;
  wire logic cs_fall = !s2_r.cs_n && s3_r.cs_n;
  wire logic held = !s2_r.hold_n;
  // Hold freezes both edges so the session resumes where it paused
  wire logic sck_rise = sel && !held && s2_r.sck && !s3_r.sck;
  wire logic sck_fall = sel && !held && !s2_r.sck && s3_r.sck;
  wire logic wp_fall = !s2_r.wp_n && s3_r.wp_n;
  // ---------------------------------------------------------------
  // Storage and state
  // ---------------------------------------------------------------
  logic [7:0] mem_r [sec_pkg::DEPTH];
  logic [7:0] page_r [16];
  logic [15:0] page_vld_r;
  sec_pkg::sec_state_t st_r;
  logic [7:0] sh_r;
  logic [2:0] bit_r;
  logic [7:0] opc_r;
  logic [sec_pkg::ADDR_W-1:0] addr_r;
  logic [7:0] out_r;
  logic so_r;
  logic wel_r;
  logic plo_r;
  logic phi_r;
  logic [1:0] nprot_r;
  logic pend_r;
  logic pend_st_r;
  logic [31:0] wcnt_r;
  logic got_byte_r;
  logic abort_r;
  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function automatic logic guarded(input logic [1:0] bp,
                                   input logic [sec_pkg::ADDR_W-1:0] a);
    unique case (bp)
      2'h0: guarded = 1'b0;
      2'h1: guarded = a >= sec_pkg::PROT_QUARTER;
      2'h2: guarded = a >= sec_pkg::PROT_HALF;
      2'h3: guarded = a >= sec_pkg::PROT_FULL;
    endcase
  endfunction : guarded
  // Bit 3 carries the ninth address bit, so it is masked out
  function automatic logic op_match(input logic [7:0] code,
                                    input logic [7:0] op);
    op_match = (code & sec_pkg::OP_X_MASK) == op;
  endfunction : op_match
  wire logic [7:0] sh_full = {sh_r[6:0], s2_r.si};
  wire logic byte_done = sck_rise && (bit_r == 3'h7);
  wire logic [7:0] status = {sec_pkg::ST_ONES, phi_r, plo_r,
                             wel_r, busy};
  wire logic is_stat_rd = sh_full == sec_pkg::OP_STAT_RD;
  wire logic is_read = op_match(sh_full, sec_pkg::OP_READ);
  wire logic is_write = op_match(sh_full, sec_pkg::OP_WRITE);
  wire logic opc_is_read = op_match(opc_r, sec_pkg::OP_READ);
  wire logic [sec_pkg::ADDR_W-1:0] addr_nxt =
    {opc_r[sec_pkg::OP_A8_BIT], sh_full};
  wire logic wr_ok = wel_r && s2_r.wp_n && !abort_r;
  wire logic [3:0] pidx = addr_r[sec_pkg::PAGE_W-1:0];
  // ---------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= sec_pkg::SEC_IDLE;
      sh_r <= 8'h00;
      bit_r <= 3'h0;
      opc_r <= 8'h00;
      addr_r <= '0;
      out_r <= 8'h00;
      got_byte_r <= 1'b0;
      abort_r <= 1'b0;
    end
    else if (!sel)
    begin
      st_r <= sec_pkg::SEC_IDLE;
      bit_r <= 3'h0;
    end
    else
    begin
      if (cs_fall)
      begin
        st_r <= sec_pkg::SEC_OPC;
        bit_r <= 3'h0;
        got_byte_r <= 1'b0;
        abort_r <= 1'b0;
      end
      if (wp_fall)
        abort_r <= 1'b1;
      if (sck_rise)
      begin
        sh_r <= sh_full;
        bit_r <= bit_r + 3'h1;
      end
      if (byte_done)
      begin
        unique case (st_r)
          sec_pkg::SEC_OPC:
          begin
            opc_r <= sh_full;
            if (is_stat_rd)
            begin
              st_r <= sec_pkg::SEC_RDOUT;
              out_r <= status;
            end
            else if (busy)
            begin
              // Dropped so a select rise after programming cannot act
              opc_r <= 8'h00;
              st_r <= sec_pkg::SEC_SKIP;
            end
            else if (is_read || is_write)
              st_r <= sec_pkg::SEC_ADDR;
            else if (sh_full == sec_pkg::OP_STAT_WR)
              st_r <= sec_pkg::SEC_SWDATA;
            else
              st_r <= sec_pkg::SEC_SKIP;
          end
          sec_pkg::SEC_ADDR:
          begin
            addr_r <= addr_nxt;
            if (opc_is_read)
            begin
              st_r <= sec_pkg::SEC_RDOUT;
              out_r <= mem_r[addr_nxt];
            end
            else
              st_r <= sec_pkg::SEC_WDATA;
          end
          sec_pkg::SEC_WDATA:
          begin
            got_byte_r <= 1'b1;
            addr_r <= {addr_r[sec_pkg::ADDR_W-1:sec_pkg::PAGE_W],
                       pidx + 4'h1};
          end
          sec_pkg::SEC_SWDATA:
          begin
            got_byte_r <= 1'b1;
            opc_r <= sh_full;
          end
          sec_pkg::SEC_RDOUT:
          begin
            if (opc_r == sec_pkg::OP_STAT_RD)
              out_r <= status;
            else
            begin
              // Address runs on past the top back to zero
              addr_r <= addr_r + 9'h001;
              out_r <= mem_r[addr_r + 9'h001];
            end
          end
          sec_pkg::SEC_SKIP:
          begin
            // A byte past the opcode voids latch set and clear
            st_r <= sec_pkg::SEC_SKIP;
            opc_r <= 8'h00;
          end
          default: st_r <= sec_pkg::SEC_SKIP;
        endcase
      end
    end
  end
  // ---------------------------------------------------------------
  // Page buffer, one slot per in-page offset
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_page
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          page_r[g] <= 8'h00;
          page_vld_r[g] <= 1'b0;
        end
        // Status polls during programming must not wipe the page
        else if (cs_fall && !busy)
          page_vld_r[g] <= 1'b0;
        else if (byte_done && st_r == sec_pkg::SEC_WDATA && pidx == g)
        begin
          page_r[g] <= sh_full;
          page_vld_r[g] <= 1'b1;
        end
      end
    end
  endgenerate
  // ---------------------------------------------------------------
  // Latch, protect bits, write cycle
  // ---------------------------------------------------------------
  wire logic end_opc = cs_rise && bit_r == 3'h0;
  wire logic start_wr = cs_rise && st_r == sec_pkg::SEC_WDATA &&
                        got_byte_r && bit_r == 3'h0 && wr_ok &&
                        !guarded({phi_r, plo_r}, addr_r);
  wire logic start_sw = cs_rise && st_r == sec_pkg::SEC_SWDATA &&
                        got_byte_r && bit_r == 3'h0 && wr_ok;
  wire logic wc_done = busy && wcnt_r == 32'h0;
  assign busy = pend_r;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wel_r <= 1'b0;
      pend_r <= 1'b0;
      pend_st_r <= 1'b0;
      wcnt_r <= 32'h0;
      nprot_r <= 2'h0;
    end
    else
    begin
      if (start_wr || start_sw)
      begin
        pend_r <= 1'b1;
        pend_st_r <= start_sw;
        wcnt_r <= 32'(WRITE_CYCLES - 1);
        if (start_sw)
          nprot_r <= opc_r[sec_pkg::ST_PHI:sec_pkg::ST_PLO];
      end
      else if (wc_done)
      begin
        pend_r <= 1'b0;
        wel_r <= 1'b0;
      end
      else if (busy)
        wcnt_r <= wcnt_r - 32'h1;
      if (!busy && end_opc && st_r == sec_pkg::SEC_SKIP)
      begin
        if (opc_r == sec_pkg::OP_LATCH_SET)
          wel_r <= 1'b1;
        if (opc_r == sec_pkg::OP_LATCH_CLR)
          wel_r <= 1'b0;
      end
    end
  end
  // Protect bits have no reset: they stand for non-volatile cells
  always_ff @(posedge clk)
  begin
    if (wc_done && pend_st_r)
    begin
      phi_r <= nprot_r[1];
      plo_r <= nprot_r[0];
    end
  end
  // A guard fall after the start leaves the running cycle alone
  always_ff @(posedge clk)
  begin
    if (wc_done && !pend_st_r)
      for (int i = 0; i < 16; i++)
        if (page_vld_r[i])
          mem_r[{addr_r[sec_pkg::ADDR_W-1:sec_pkg::PAGE_W],
                 4'(i)}] <= page_r[i];
  end
  // ---------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------
  wire logic [2:0] obit = 3'h7 - bit_r;
  wire logic in_rdout = st_r == sec_pkg::SEC_RDOUT;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      so_r <= 1'b0;
    else if (sck_fall && in_rdout)
      so_r <= out_r[obit];
  end
  assign so_o = so_r;
  assign so_oe_n = !(sel && !held && in_rdout);
endmodule : sec_core
`default_nettype wire

// ### bench/sec_checker.sv
// Pin-level assertions for the serial eeprom core
`timescale 1ns/1ns
`default_nettype none
module sec_checker #(
  parameter int WRITE_CYCLES = 250000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire sec_pkg::sec_pins_t pins,
  input wire logic so_o,
  input wire logic so_oe_n,
  input wire logic busy
);
  int bcnt_r;
  logic [4:0] rise_r;
  logic sck_r;
  // Raw pins lead the core by its sync stages
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bcnt_r <= 0;
      rise_r <= 5'h00;
      sck_r <= 1'b0;
    end
    else
    begin
      bcnt_r <= busy ? bcnt_r + 1 : 0;
      sck_r <= pins.sck;
      if (pins.cs_n)
        rise_r <= 5'h00;
      else if (pins.sck && !sck_r && rise_r < 5'h1f)
        rise_r <= rise_r + 5'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_desel_float: assert property (pins.cs_n [*5] |-> so_oe_n)
    else $error("output driven while deselected");
  a_hold_float: assert property (!pins.hold_n [*5] |-> so_oe_n)
    else $error("output driven in hold");
  a_start_rise: assert property ($rose(busy) |-> pins.cs_n && pins.wp_n)
    else $error("programming began without select rise");
  a_busy_len: assert property ($fell(busy) |-> bcnt_r == WRITE_CYCLES)
    else $error("busy length wrong");
  a_busy_cap: assert property (busy |-> bcnt_r < WRITE_CYCLES)
    else $error("busy overran");
  a_so_fall: assert property (!so_oe_n && $changed(so_o) |-> !$past(pins.sck, 2))
    else $error("output moved off a falling clock");
  a_opc_first: assert property ($fell(so_oe_n) |-> rise_r > 5'h07)
    else $error("output before full opcode");
  a_rearm_gap: assert property ($fell(busy) |-> !busy [*8])
    else $error("programming restarted at once");
  c_prog: cover property ($rose(busy));
  c_out: cover property ($fell(so_oe_n));
  c_hold: cover property (!pins.hold_n && !pins.cs_n);
endmodule : sec_checker
bind sec_core sec_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .clk(clk), .rstn(rstn), .pins(pins),
  .so_o(so_o), .so_oe_n(so_oe_n), .busy(busy));
`default_nettype wire

// ### bench/sec_host.sv
// Spi host model driving the core's pins, mode 0
`timescale 1ns/1ns
`default_nettype none
module sec_host (
  input wire logic clk,
  input wire logic so_o,
  input wire logic so_oe_n,
  output var sec_pkg::sec_pins_t p
);
  // Idle bus: deselected, clock low, guard and hold released
  initial p = 5'h13;
  task automatic guard(input logic v);
    p.wp_n = v;
  endtask : guard
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Select moves only with the clock parked low
  task automatic cs(input logic v);
    tick(2);
    p.cs_n = v;
    tick(6);
  endtask : cs
  // Floating output reads unknown, never a stale bit
  task automatic xb(input logic [7:0] d, input int n, output logic [7:0] q);
    q = 8'hxx;
    for (int i = n - 1; i >= 0; i--)
    begin
      p.si = d[i];
      tick(4);
      p.sck = 1'b1;
      q[i] = so_oe_n ? 1'bx : so_o;
      tick(4);
      p.sck = 1'b0;
    end
  endtask : xb
  task automatic pause(output logic fl);
    tick(2);
    p.hold_n = 1'b0;
    p.si = ~p.si;
    tick(8);
    fl = so_oe_n;
    p.hold_n = 1'b1;
    tick(2);
  endtask : pause
endmodule : sec_host
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the serial eeprom core
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [8:0] BA [3] = '{9'h010, 9'h101, 9'h181};
  logic clk;
  logic rstn;
  logic so_o, so_oe_n, busy, g, f;
  sec_pkg::sec_pins_t pins;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [7:0] q, s;
  logic [7:0] mem [512];
  always #10 clk = ~clk;
  // Short write cycle keeps the run brief
  sec_core #(.WRITE_CYCLES(600)) dut (.clk(clk), .rstn(rstn),
    .pins(pins), .so_o(so_o), .so_oe_n(so_oe_n), .busy(busy));
  sec_host h (.clk(clk), .so_o(so_o), .so_oe_n(so_oe_n), .p(pins));
  task automatic wrap_up;
    $display("checks %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] gv, e, input string m);
    tests_run++;
    if (gv !== e)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic op(input logic [7:0] b);
    h.cs(1'b0);
    h.xb(b, 8, q);
    h.cs(1'b1);
  endtask : op
  task automatic rs;
    h.cs(1'b0);
    h.xb(8'h05, 8, q);
    h.xb(8'h00, 8, s);
    h.cs(1'b1);
  endtask : rs
  task automatic poll;
    int n;
    n = 0;
    s = 8'h01;
    while (s[0] !== 1'b0 && n < 20)
    begin
      rs();
      n++;
    end
    chk({7'h00, s[0]}, 8'h00, "busy stuck");
  endtask : poll
  task automatic wsr(input logic [7:0] d);
    op(8'h06);
    h.cs(1'b0);
    h.xb(8'h01, 8, q);
    h.xb(d, 8, q);
    h.cs(1'b1);
    poll();
    rs();
    chk(s, {4'hf, d[3:2], 2'b00}, "status");
  endtask : wsr
  // md: 0 good, 1 no latch, 2 guard low, 3 guard falls, 4 odd bits,
  // 5 refused, 6 good with busy probe
  task automatic wr(input logic [8:0] a, input int nb,
                    input logic [7:0] d, input int md);
    if (md != 1)
      op(8'h06);
    h.guard(md != 2);
    h.cs(1'b0);
    h.xb({4'h0, a[8], 3'h2}, 8, q);
    h.xb(a[7:0], 8, q);
    for (int k = 0; k < nb; k++)
      h.xb(d + 8'(k), 8, q);
    if (md == 4)
      h.xb(8'hff, 3, q);
    // Guard pulse that recovers before deselect must still abort
    if (md == 3)
    begin
      h.guard(1'b0);
      h.tick(4);
    end
    h.guard(md != 2);
    h.cs(1'b1);
    h.guard(1'b1);
    if (md == 6)
    begin
      rs();
      chk(s, 8'hf3, "status while busy");
      wr(9'h000, 1, 8'ha5, 5);
    end
    poll();
    for (int k = 0; k < nb && (md == 0 || md == 6); k++)
      mem[{a[8:4], a[3:0] + 4'(k)}] = d + 8'(k);
  endtask : wr
  task automatic rd(input logic [8:0] a, input int n);
    h.cs(1'b0);
    h.xb({4'h0, a[8], 3'h3}, 8, q);
    h.xb(a[7:0], 8, q);
    for (int k = 0; k < n; k++)
    begin
      h.xb(8'h00, 8, q);
      chk(q, mem[a + 9'(k)], "read data");
    end
    h.cs(1'b1);
  endtask : rd
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: timeout", $time);
      wrap_up();
    end
  end
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk({6'h00, so_oe_n, busy}, 8'h02, "reset pins");
    h.tick(4);
    rs();
    chk({s[7:4], s[1:0]}, 8'h3c, "start status");
    op(8'h06);
    rs();
    chk({7'h00, s[1]}, 8'h01, "latch set");
    op(8'h04);
    rs();
    chk({7'h00, s[1]}, 8'h00, "latch clear");
    // One stray bit, then a whole stray byte, after latch set
    for (int n = 1; n < 9; n += 7)
    begin
      h.cs(1'b0);
      h.xb(8'h06, 8, q);
      h.xb(8'h00, n, q);
      h.cs(1'b1);
      rs();
      chk({7'h00, s[1]}, 8'h00, "late select");
    end
    h.cs(1'b0);
    h.xb(8'hff, 8, q);
    h.xb(8'h00, 8, q);
    h.cs(1'b1);
    chk(q, 8'hxx, "unknown opcode");
    $display("test commands done");
    wsr(8'hff);
    for (int c = 0; c < 4; c++)
    begin
      wsr({4'h0, 2'(c), 2'b00});
      foreach (BA[j])
      begin
        g = (c == 3) || (c == 2 && BA[j][8]) || (c == 1 && BA[j][7]);
        wr(BA[j], 1, 8'h60 + 8'(4 * c + j), g ? 5 : 0);
        rd(BA[j], 1);
      end
    end
    wsr(8'h00);
    $display("test protect done");
    for (int md = 1; md < 5; md++)
      wr(9'h101, 1, 8'h10 + 8'(md), md);
    rd(9'h101, 1);
    wr(9'h000, 1, 8'h5a, 0);
    wr(9'h1f5, 17, 8'h40, 6);
    rd(9'h1f0, 16);
    rd(9'h1fe, 3);
    $display("test array done");
    h.cs(1'b0);
    h.xb(8'h0b, 8, q);
    h.xb(8'h01, 8, q);
    h.xb(8'h00, 4, q);
    h.pause(f);
    h.xb(8'h00, 4, s);
    h.cs(1'b1);
    chk({7'h00, f}, 8'h01, "hold float");
    chk({q[3:0], s[3:0]}, mem[9'h101], "hold read");
    $display("test hold done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
